// File: design/mux_ctrl_params.svh
/*
 * Timing counts, field positions and pin encodings for the multiplexed-address controller.
 * Assumes it is included by bare name from every file that needs these figures.
 */
`ifndef MUX_CTRL_PARAMS_SVH
`define MUX_CTRL_PARAMS_SVH

// Row cycle, read delay and write delay per configuration, in clocks (non-multiplexed base)
`define CFG1_RC 4
`define CFG1_RL 5
`define CFG1_WL 6
`define CFG2_RC 6
`define CFG2_RL 7
`define CFG2_WL 8
`define CFG3_RC 8
`define CFG3_RL 9
`define CFG3_WL 10
`define CFG4_RC 3
`define CFG4_RL 4
`define CFG4_WL 5
`define CFG5_RC 5
`define CFG5_RL 6
`define CFG5_WL 7

// Extra latency while the address is split over two clocks
`define MUX_EXTRA_CLKS 1
// Least spacing of a write followed by a read to the same bank
`define WR_RD_MIN_CLKS 4
// Least row cycle the controller may ever assume
`define MIN_RC_CLKS 3

// Burst selector codes and beat counts
`define BURST_SEL_2 2'h0
`define BURST_SEL_4 2'h1
`define BURST_SEL_8 2'h2
`define BEATS_2 4'h2
`define BEATS_4 4'h4
`define BEATS_8 4'h8
`define MAX_BEATS 8

// Address bit that selects multiplexed addressing in a mode load
`define MUX_SEL_BIT 5
// Mode load settling time in clocks
`define MODE_SETTLE_CLKS 6

`define NUM_BANKS 8
`define SCHED_SLOTS 32

`endif

// File: design/mux_ctrl_pkg.sv
/*
 * Types shared by the multiplexed-address controller and its self-checking bench.
 * Assumes nothing of its surroundings.
 */
package mux_ctrl_pkg;
    typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_REFRESH, CMD_MODE} cmd_t;
    typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_PHASE2, ST_SETTLE} state_t;
endpackage

// File: design/bank_timer.sv
/*
 * Per-bank row-cycle down counters; a bank is idle when its counter is zero.
 * Assumes loads arrive at most one per clock from the controller that owns it.
 */
`timescale 1ns/1ps
`include "mux_ctrl_params.svh"

module bank_timer #(
    parameter int NB = `NUM_BANKS,
    parameter int CW = 4
) (
    input  wire logic          core_clk,
    input  wire logic          resetn,
    input  wire logic          loadEn,
    input  wire logic [2:0]    loadBank,
    input  wire logic [CW-1:0] loadVal,
    output logic      [NB-1:0] bankIdle
);
    logic [CW-1:0] cnt [NB];

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < NB; i++)
                cnt[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < NB; i++)
            begin
                if (loadEn && loadBank == 3'(i))
                    cnt[i] <= loadVal;
                else if (cnt[i] != '0)
                    cnt[i] <= cnt[i] - CW'(1);
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < NB; i++)
            bankIdle[i] = (cnt[i] == '0);
    end
endmodule

// File: design/mux_addr_ctrl.sv
/*
 * Host-side command controller for a DDR low-latency DRAM in multiplexed address mode.
 * Assumes user requests and pin inputs are synchronous to core_clk; data beats are one per clock.
 */
`timescale 1ns/1ps
`include "mux_ctrl_params.svh"

module mux_addr_ctrl
    import mux_ctrl_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int DQ_W   = 18
) (
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    input  wire logic [2:0]               cfgSel,
    input  wire logic [1:0]               burstSel,
    input  wire logic                     reqValid,
    input  wire cmd_t                     reqCmd,
    input  wire logic [2:0]               reqBank,
    input  wire logic [ADDR_W-1:0]        reqAddr,
    input  wire logic [DQ_W*`MAX_BEATS-1:0] reqWdata,
    input  wire logic [DQ_W-1:0]          memDqIn,
    output logic                          reqReady,
    output logic                          cfgError,
    output logic                          muxActive,
    output logic                          memCsN,
    output logic                          memWeN,
    output logic                          memRefN,
    output logic [2:0]                    memBank,
    output logic [ADDR_W-1:0]             memAddr,
    output logic [DQ_W-1:0]               memDqOut,
    output logic                          memDqOe,
    output logic                          rdValid,
    output logic [DQ_W-1:0]               rdData
);
    localparam int HALF = ADDR_W / 2;
    localparam int NS   = `SCHED_SLOTS;

    function automatic logic [3:0] cfgRc(input logic [2:0] s);
        case (s)
            3'h1: return 4'(`CFG1_RC);
            3'h2: return 4'(`CFG2_RC);
            3'h3: return 4'(`CFG3_RC);
            3'h4: return 4'(`CFG4_RC);
            default: return 4'(`CFG5_RC);
        endcase
    endfunction

    function automatic logic [4:0] cfgLat(input logic [2:0] s, input logic wr);
        case (s)
            3'h1: return wr ? 5'(`CFG1_WL) : 5'(`CFG1_RL);
            3'h2: return wr ? 5'(`CFG2_WL) : 5'(`CFG2_RL);
            3'h3: return wr ? 5'(`CFG3_WL) : 5'(`CFG3_RL);
            3'h4: return wr ? 5'(`CFG4_WL) : 5'(`CFG4_RL);
            default: return wr ? 5'(`CFG5_WL) : 5'(`CFG5_RL);
        endcase
    endfunction

    function automatic logic [NS-1:0] winMask(input logic [4:0] start, input logic [3:0] len);
        logic [NS-1:0] ones;
        ones = (NS'(1) << len) - NS'(1);
        return ones << start;
    endfunction

    state_t              state;
    state_t              next_state;
    cmd_t                holdCmd;
    logic [2:0]          holdBank;
    logic [ADDR_W-1:0]   holdAddr;
    logic [DQ_W*`MAX_BEATS-1:0] holdWdata;
    logic [3:0]          settleCnt;
    logic [NS-1:0]       resv;
    logic [NS-1:0]       wrMark;
    logic [NS-1:0]       rdMark;
    logic [DQ_W-1:0]     dqSlot [NS];
    logic [`NUM_BANKS-1:0] bankIdle;

    // Burst-8 is refused outright in configuration 4
    wire        cfgOk    = (cfgSel >= 3'h1) && (cfgSel <= 3'h5) && (burstSel != 2'h3)
                           && !(cfgSel == 3'h4 && burstSel == `BURST_SEL_8);
    wire [3:0]  beats    = (burstSel == `BURST_SEL_2) ? `BEATS_2 :
                           (burstSel == `BURST_SEL_4) ? `BEATS_4 : `BEATS_8;
    wire [4:0]  muxAdd   = muxActive ? 5'(`MUX_EXTRA_CLKS) : 5'h0;
    wire [4:0]  rl       = cfgLat(cfgSel, 1'b0) + muxAdd;
    wire [4:0]  wl       = cfgLat(cfgSel, 1'b1) + muxAdd;
    wire [4:0]  wrStart  = wl - 5'h1;
    wire [3:0]  rc       = cfgRc(cfgSel);
    wire [NS-1:0] resvShift = resv >> 1;
    wire [NS-1:0] wrWin  = winMask(wrStart, beats);
    wire [NS-1:0] rdWin  = winMask(rl, beats);
    // One guard beat after each burst keeps the bus from turning round mid-beat
    wire [NS-1:0] wrGuard = winMask(wrStart, beats + 4'h1);
    wire [NS-1:0] rdGuard = winMask(rl, beats + 4'h1);
    wire        isRead   = (holdCmd == CMD_READ);
    wire        isWrite  = (holdCmd == CMD_WRITE);
    wire        isRef    = (holdCmd == CMD_REFRESH);
    wire        isMode   = (holdCmd == CMD_MODE);
    wire        bankOk   = isMode || bankIdle[holdBank];
    wire        busOk    = isRead  ? ((resvShift & rdGuard) == '0) :
                           isWrite ? ((resvShift & wrGuard) == '0) :
                           isMode  ? (resv == '0) : 1'b1;
    wire        issue    = (state == ST_HOLD) && bankOk && busOk && cfgOk;
    wire        accept   = reqValid && reqReady;
    wire        wrNew    = issue && isWrite;
    wire        rdNew    = issue && isRead;
    wire        enterMux = isMode && !muxActive && holdAddr[`MUX_SEL_BIT];
    // Write then read to one bank needs four clocks; writes load that spacing when the row cycle is shorter
    wire [3:0]  rcLoad   = (isWrite && rc < 4'(`WR_RD_MIN_CLKS)) ? 4'(`WR_RD_MIN_CLKS - 1) : rc - 4'h1;

    bank_timer #(
        .NB (`NUM_BANKS),
        .CW (4)
    ) u_bank_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .loadEn   (issue && !isMode),
        .loadBank (holdBank),
        .loadVal  (rcLoad),
        .bankIdle (bankIdle)
    );

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (accept)
                    next_state = ST_HOLD;
            ST_HOLD:
                if (issue)
                begin
                    if (muxActive && !isRef)
                        next_state = ST_PHASE2;
                    else if (enterMux)
                        next_state = ST_SETTLE;
                    else
                        next_state = ST_IDLE;
                end
            ST_PHASE2:
                next_state = ST_IDLE;
            ST_SETTLE:
                if (settleCnt == 4'h0)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state     <= ST_IDLE;
            reqReady  <= 1'b0;
            cfgError  <= 1'b0;
            muxActive <= 1'b0;
            settleCnt <= 4'h0;
        end
        else
        begin
            state     <= next_state;
            reqReady  <= (next_state == ST_IDLE) && cfgOk;
            cfgError  <= !cfgOk;
            if (issue && enterMux)
                settleCnt <= 4'(`MODE_SETTLE_CLKS - 1);
            else if (state == ST_SETTLE && settleCnt != 4'h0)
                settleCnt <= settleCnt - 4'h1;
            if (state == ST_SETTLE && settleCnt == 4'h0)
                muxActive <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            holdCmd   <= CMD_READ;
            holdBank  <= 3'h0;
            holdAddr  <= '0;
            holdWdata <= '0;
        end
        else if (accept)
        begin
            holdCmd   <= reqCmd;
            holdBank  <= reqBank;
            holdAddr  <= reqAddr;
            holdWdata <= reqWdata;
        end
    end

    // Command pins; the device acts on the edge after the first phase
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            memCsN  <= 1'b1;
            memWeN  <= 1'b1;
            memRefN <= 1'b1;
            memBank <= 3'h0;
            memAddr <= '0;
        end
        else if (issue)
        begin
            memCsN  <= 1'b0;
            memWeN  <= !(isWrite || isMode);
            memRefN <= !(isRef || isMode);
            memBank <= holdBank;
            memAddr <= muxActive ? ADDR_W'(holdAddr[HALF-1:0]) : holdAddr;
        end
        else
        begin
            memCsN  <= 1'b1;
            memWeN  <= 1'b1;
            memRefN <= 1'b1;
            if (state == ST_PHASE2)
                memAddr <= ADDR_W'(holdAddr[ADDR_W-1:HALF]);
        end
    end

    // Data schedule: slot k is driven or sampled k+1 clocks from now
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            resv   <= '0;
            wrMark <= '0;
            rdMark <= '0;
            for (int k = 0; k < NS; k++)
                dqSlot[k] <= '0;
        end
        else
        begin
            resv   <= resvShift | (wrNew ? wrGuard : '0) | (rdNew ? rdGuard : '0);
            wrMark <= (wrMark >> 1) | (wrNew ? wrWin : '0);
            rdMark <= (rdMark >> 1) | (rdNew ? rdWin : '0);
            for (int k = 0; k < NS; k++)
            begin
                if (wrNew && wrWin[k])
                    dqSlot[k] <= holdWdata[DQ_W*(k-int'(wrStart)) +: DQ_W];
                else if (k == NS-1)
                    dqSlot[k] <= '0;
                else
                    dqSlot[k] <= dqSlot[k+1];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            memDqOut <= '0;
            memDqOe  <= 1'b0;
            rdValid  <= 1'b0;
            rdData   <= '0;
        end
        else
        begin
            memDqOut <= dqSlot[0];
            memDqOe  <= wrMark[0];
            rdValid  <= rdMark[0];
            rdData   <= memDqIn;
        end
    end

    logic [2:0] lastBank;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            lastBank <= 3'h0;
        else if (issue)
            lastBank <= holdBank;
    end

    localparam int SETTLE_BOUND = `MODE_SETTLE_CLKS + 2;

    // High half is launched one clock after the first phase, so it is seen two samples on
    phase_two_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (issue && muxActive && !isRef) |-> ##2 (memCsN && memAddr == ($past(holdAddr, 2) >> HALF)))
        else $error("second address phase missing");
    refresh_single_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (issue && muxActive && isRef) |=> (state == ST_IDLE && reqReady == cfgOk))
        else $error("refresh did not free the command slot");
    read_lat_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (rdNew && muxActive && cfgSel == 3'h1) |-> ##8 rdValid)
        else $error("multiplexed read delay wrong");
    read_plain_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (rdNew && !muxActive && cfgSel == 3'h1) |-> ##6 !rdValid ##1 rdValid)
        else $error("plain read delay wrong");
    write_four_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (wrNew && muxActive && cfgSel == 3'h3 && burstSel == `BURST_SEL_4) |-> ##12 memDqOe[*4] ##1 !memDqOe)
        else $error("four-beat write length or delay wrong");
    read_two_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (rdNew && muxActive && cfgSel == 3'h2 && burstSel == `BURST_SEL_2) |-> ##10 rdValid[*2] ##1 !rdValid)
        else $error("two-beat read length wrong");
    cfg_refuse_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (cfgSel == 3'h4 && burstSel == `BURST_SEL_8) |=> (cfgError && !reqReady))
        else $error("burst eight accepted in configuration 4");
    bank_gap_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (issue && !isMode) |=> !(issue && !isMode && holdBank == lastBank)[*2])
        else $error("row cycle violated on one bank");
    settle_wait_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (issue && enterMux) |=> !reqReady[*6] ##[1:SETTLE_BOUND] muxActive)
        else $error("mode settle time not kept");

    cover_refresh: cover property (@(posedge core_clk) disable iff (!resetn)
        (issue && isRef && muxActive) ##[1:4] (issue && isRef));
    cover_wr_rd: cover property (@(posedge core_clk) disable iff (!resetn)
        wrNew ##[1:12] rdNew);
    cover_mux: cover property (@(posedge core_clk) disable iff (!resetn) $rose(muxActive));
    cover_read: cover property (@(posedge core_clk) disable iff (!resetn) rdValid);
endmodule

// File: dv/mux_dv_pkg.sv
/*
 * Per-configuration timing tables for the bench and the device model.
 * Assumes the design parameter header is on the include path.
 */
`include "mux_ctrl_params.svh"
package mux_dv_pkg;
    localparam int RC_T [8] = '{0, `CFG1_RC, `CFG2_RC, `CFG3_RC, `CFG4_RC, `CFG5_RC, 0, 0};
    localparam int RL_T [8] = '{0, `CFG1_RL, `CFG2_RL, `CFG3_RL, `CFG4_RL, `CFG5_RL, 0, 0};
    localparam int WL_T [8] = '{0, `CFG1_WL, `CFG2_WL, `CFG3_WL, `CFG4_WL, `CFG5_WL, 0, 0};
endpackage

// File: dv/mux_dev_model.sv
/*
 * Behavioural DRAM device on the controller pins: decodes commands, returns and captures bursts.
 * Assumes pins settle by the falling edge and cfgSel/burstSel mirror the device mode.
 */
`timescale 1ns/1ps
`include "mux_ctrl_params.svh"

module mux_dev_model
    import mux_dv_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int DQ_W   = 18
) (
    input  wire logic              core_clk,
    input  wire logic [2:0]        cfgSel,
    input  wire logic [1:0]        burstSel,
    input  wire logic              memCsN,
    input  wire logic              memWeN,
    input  wire logic              memRefN,
    input  wire logic [2:0]        memBank,
    input  wire logic [ADDR_W-1:0] memAddr,
    input  wire logic [DQ_W-1:0]   memDqOut,
    input  wire logic              memDqOe,
    output logic      [DQ_W-1:0]   memDqIn,
    output int                     violations
);
    logic [DQ_W-1:0]   mem [int];
    int                rdKey [64] = '{default: -1};
    int                wrKey [64] = '{default: -1};
    int                lastN [8] = '{default: -100};
    bit                lastWr [8];
    int                n = 0;
    int                k;
    int                modeN = -100;
    bit                mux = 0;
    bit                pend = 0;
    logic [1:0]        pCode;
    logic [2:0]        pBank;
    logic [ADDR_W-1:0] pAddr;
    wire  [1:0]        code = {memWeN, memRefN};

    initial
    begin
        memDqIn = '0;
        violations = 0;
    end

    // Slots indexed by falling-edge count; 64 outlasts the longest latency plus a burst
    task automatic sched(input bit wr, input int key, input int t);
        int lat;
        lat = (wr ? WL_T[cfgSel] : RL_T[cfgSel]) + int'(mux);
        for (int b = 0; b < (2 << burstSel); b++)
        begin
            if (wr)
                wrKey[(t + lat + b) % 64] = key * 8 + b;
            else
                rdKey[(t + lat + b) % 64] = key * 8 + b;
        end
    endtask

    task automatic accept(input logic [1:0] c, input logic [2:0] b, input logic [ADDR_W-1:0] a, input int t);
        if (t - modeN < `MODE_SETTLE_CLKS)
            violations++;
        if (c == 2'b00)
        begin
            if (a[`MUX_SEL_BIT] && !mux)
                modeN = t;
            mux = mux | a[`MUX_SEL_BIT];
        end
        else
        begin
            if (t - lastN[b] < RC_T[cfgSel] || (lastWr[b] && c == 2'b11 && t - lastN[b] < `WR_RD_MIN_CLKS))
                violations++;
            lastN[b] = t;
            lastWr[b] = (c == 2'b01);
            if (c != 2'b10)
                sched(c == 2'b01, int'({b, a}), t);
        end
    endtask

    always @(negedge core_clk)
    begin
        n = n + 1;
        k = rdKey[n % 64];
        rdKey[n % 64] = -1;
        // Idle bus toggles so a late sample never matches by chance
        memDqIn <= (k >= 0 && mem.exists(k)) ? mem[k] : ~memDqIn;
        k = wrKey[n % 64];
        wrKey[n % 64] = -1;
        if ((k >= 0) != (memDqOe === 1'b1))
            violations++;
        else if (k >= 0)
            mem[k] = memDqOut;
        if (pend)
        begin
            pend = 0;
            if (memCsN !== 1'b1)
                violations++;
            accept(pCode, pBank, {memAddr[9:0], pAddr[9:0]}, n - 1);
        end
        else if (memCsN === 1'b0)
        begin
            if (cfgSel == 3'h4 && burstSel == `BURST_SEL_8)
                violations++;
            // Refresh carries only a bank, so it completes in one phase
            if (mux && code != 2'b10)
            begin
                pend = 1;
                pCode = code;
                pBank = memBank;
                pAddr = memAddr;
            end
            else
                accept(code, memBank, memAddr, n);
        end
    end
endmodule

// File: dv/mux_addr_ctrl_bench.sv
/*
 * Self-checking bench: random and corner traffic through the controller into the device model.
 * Assumes the design package, parameter header and dv timing package compile first.
 */
`timescale 1ns/1ps
`include "mux_ctrl_params.svh"

module mux_addr_ctrl_bench
    import mux_ctrl_pkg::*, mux_dv_pkg::*;
;
    localparam int ADDR_W = 20;
    localparam int DQ_W   = 18;
    localparam logic [4:0] BAD [5] = '{5'h00, 5'h18, 5'h1c, 5'h07, 5'h12};

    logic                 core_clk;
    logic                 resetn;
    logic [2:0]           cfgSel;
    logic [1:0]           burstSel;
    logic                 reqValid;
    cmd_t                 reqCmd;
    logic [2:0]           reqBank, memBank;
    logic [ADDR_W-1:0]    reqAddr, memAddr;
    logic [DQ_W*8-1:0]    reqWdata;
    logic [DQ_W-1:0]      memDqIn, memDqOut, rdData;
    logic                 reqReady, cfgError, muxActive, memCsN, memWeN, memRefN, memDqOe, rdValid;
    logic [DQ_W-1:0]      shadow [int];
    logic [DQ_W-1:0]      dataQ [$];
    int                   timeQ [$];
    int                   written [$];
    int                   violations;
    int                   nMismatch = 0;
    int                   checkCount = 0;
    int                   cyc = 0;
    int                   ncnt = 0;
    int                   muxExp = 0;
    int                   refReq = 0;
    int                   refSeen = 0;
    int                   seed;

    mux_addr_ctrl #(.ADDR_W(ADDR_W), .DQ_W(DQ_W)) mux_addr_ctrl_i (
        .core_clk, .resetn, .cfgSel, .burstSel, .reqValid, .reqCmd, .reqBank, .reqAddr,
        .reqWdata, .memDqIn, .reqReady, .cfgError, .muxActive, .memCsN, .memWeN, .memRefN,
        .memBank, .memAddr, .memDqOut, .memDqOe, .rdValid, .rdData
    );
    mux_dev_model #(.ADDR_W(ADDR_W), .DQ_W(DQ_W)) mux_dev_model_i (
        .core_clk, .cfgSel, .burstSel, .memCsN, .memWeN, .memRefN, .memBank, .memAddr,
        .memDqOut, .memDqOe, .memDqIn, .violations
    );

    always #20 core_clk = ~core_clk;

    task automatic summarize;
        if (nMismatch == 0 && checkCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checkCount++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Falling-edge count at which a read beat must show on rdValid
    function automatic int readDue(input int cmdTime, input int beat);
        return cmdTime + RL_T[cfgSel] + muxExp + 1 + beat;
    endfunction

    // Worst case is about 20 clocks per request, well inside this ceiling
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            nMismatch++;
            summarize();
        end
    end

    always @(negedge core_clk)
    begin
        ncnt++;
        if (memCsN === 1'b0 && memWeN === 1'b1 && memRefN === 1'b1)
            for (int b = 0; b < (2 << burstSel); b++)
                timeQ.push_back(readDue(ncnt, b));
        if (memCsN === 1'b0 && memWeN === 1'b1 && memRefN === 1'b0)
            refSeen++;
        if (rdValid === 1'b1)
        begin
            check("read beat time", timeQ.size() > 0 ? timeQ.pop_front() : -1, ncnt);
            check("read beat data", dataQ.size() > 0 ? dataQ.pop_front() : 'x, rdData);
        end
    end

    task automatic issue(input cmd_t c, input logic [2:0] b, input logic [ADDR_W-1:0] a);
        int key;
        int w;
        key = int'({b, a});
        @(negedge core_clk);
        reqValid = 1;
        reqCmd = c;
        reqBank = b;
        reqAddr = a;
        for (int i = 0; i < 8; i++)
            reqWdata[DQ_W*i +: DQ_W] = DQ_W'($urandom);
        for (w = 0; w < 300 && reqReady !== 1'b1; w++)
            @(negedge core_clk);
        check("request taken", 1, reqReady);
        for (int i = 0; i < (2 << burstSel); i++)
            if (c == CMD_WRITE)
                shadow[key * 8 + i] = reqWdata[DQ_W*i +: DQ_W];
            else if (c == CMD_READ)
                dataQ.push_back(shadow[key * 8 + i]);
        if (c == CMD_WRITE)
            written.push_back(key);
        refReq += int'(c == CMD_REFRESH);
        @(negedge core_clk);
        reqValid = 0;
    endtask

    // Long enough for the slowest write burst to leave the bus before settings change
    task automatic drain;
        for (int w = 0; w < 400 && (timeQ.size() > 0 || reqReady !== 1'b1); w++)
            @(negedge core_clk);
        repeat (24) @(negedge core_clk);
    endtask

    task automatic block(input logic [2:0] c, input logic [1:0] s);
        logic [ADDR_W-1:0] a;
        int                k;
        drain();
        cfgSel = c;
        burstSel = s;
        written.delete();
        repeat (2) @(negedge core_clk);
        a = ADDR_W'($urandom);
        issue(CMD_WRITE, 3'h5, a);
        issue(CMD_READ, 3'h5, a);
        issue(CMD_WRITE, 3'h5, a);
        issue(CMD_READ, 3'h5, a);
        issue(CMD_REFRESH, 3'h5, '0);
        issue(CMD_REFRESH, 3'h6, '0);
        repeat (20)
        begin
            k = $urandom_range(2);
            if (k == 0)
            begin
                k = written[$urandom_range(written.size() - 1)];
                issue(CMD_READ, 3'(k >> ADDR_W), ADDR_W'(k));
            end
            else
                issue(k == 1 ? CMD_WRITE : CMD_REFRESH, 3'($urandom), ADDR_W'($urandom));
        end
    endtask

    initial
    begin
        core_clk = 0;
        resetn = 0;
        cfgSel = 3'h1;
        burstSel = `BURST_SEL_2;
        reqValid = 0;
        reqCmd = CMD_READ;
        reqBank = '0;
        reqAddr = '0;
        reqWdata = '0;
        seed = $urandom(32'haf4f);
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1;
        repeat (2) @(negedge core_clk);
        check("ready after reset", 1, reqReady);
        check("mux after reset", 0, muxActive);
        check("error after reset", 0, cfgError);
        foreach (BAD[i])
        begin
            {cfgSel, burstSel} = BAD[i];
            repeat (3) @(negedge core_clk);
            check("bad setting error", 1, cfgError);
            check("bad setting ready", 0, reqReady);
        end
        {cfgSel, burstSel} = 5'h04;
        repeat (3) @(negedge core_clk);
        for (int m = 0; m < 2; m++)
        begin
            if (m == 1)
            begin
                issue(CMD_MODE, 3'h0, 20'h0_0020);
                drain();
                muxExp = 1;
                check("mux entered", 1, muxActive);
                issue(CMD_MODE, 3'h0, 20'h0_0020);
            end
            for (int c = 1; c < 6; c++)
                for (int s = 0; s < 3; s++)
                    if (c != 4 || s != 2)
                        block(3'(c), 2'(s));
        end
        drain();
        check("device timing faults", 0, violations);
        check("refresh count", refReq, refSeen);
        check("reads outstanding", 0, timeQ.size());
        summarize();
    end
endmodule
